// ---- hdl/fwb_pkg.sv ----
package fwb_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int MEM_WORDS = 256;
   localparam int PART_BIT = 7;
   localparam int BLK_LSB = 6;
   localparam int BLK_W = ADDR_W - BLK_LSB;
   localparam int BUF_WORDS = 32;
   localparam int CNT_W = 6;
   localparam int IDX_W = 5;
   localparam int FIFO_DEPTH = 4;
   localparam int REQ_W = 2 + ADDR_W + DATA_W;

   localparam int CLK_NS = 20;
   localparam int WORD_PROG_NS = 2000;
   localparam int BUF_PROG_NS = 8000;
   localparam int WORD_PROG_CYC = (WORD_PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUF_PROG_CYC = (BUF_PROG_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W = 10;

   localparam logic [7:0] CMD_WORD_PROG = 8'h40;
   localparam logic [7:0] CMD_WORD_PROG_ALT = 8'h10;
   localparam logic [7:0] CMD_BUF_SETUP = 8'he8;
   localparam logic [7:0] CMD_BUF_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_QUERY = 8'h98;

   localparam logic [7:0] SR_READY_M = 8'h80;
   localparam logic [7:0] SR_SEQ_M = 8'h20;
   localparam logic [7:0] SR_PROG_M = 8'h10;
   localparam logic [7:0] SR_SUPPLY_M = 8'h08;
   localparam logic [7:0] SR_LOCK_M = 8'h02;
   localparam int SR_READY_BIT = 7;

   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
   // arbitrary identifier and query answers
   localparam logic [DATA_W-1:0] ID_WORD = 16'h5a3c;
   localparam logic [DATA_W-1:0] QUERY_WORD = 16'h0011;

   typedef enum logic [1:0] {
      FWB_RD_ARRAY = 2'b00,
      FWB_RD_STATUS = 2'b01,
      FWB_RD_ID = 2'b10,
      FWB_RD_QUERY = 2'b11
   } fwb_rdmode_e;

   typedef enum logic [1:0] {
      FWB_OP_WRITE = 2'b00,
      FWB_OP_READ = 2'b01,
      FWB_OP_WORD_PROG = 2'b10
   } fwb_op_e;

   function automatic logic fwb_part_of(input logic [ADDR_W-1:0] a);
      return a[PART_BIT];
   endfunction

   function automatic logic [BLK_W-1:0] fwb_blk_of(
      input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:BLK_LSB];
   endfunction
endpackage

// ---- hdl/fwb_bus_if.sv ----
`timescale 1ns/1ns
interface fwb_bus_if;
   logic we;
   logic re;
   logic [fwb_pkg::ADDR_W-1:0] addr;
   logic [fwb_pkg::DATA_W-1:0] wdata;
   logic [fwb_pkg::DATA_W-1:0] rdata;
   logic rvalid;

   modport dev(input we, input re, input addr, input wdata,
      output rdata, output rvalid);
   modport host(output we, output re, output addr, output wdata,
      input rdata, input rvalid);
endinterface

// ---- hdl/fwb_dev_end.sv ----
// What this block does
// R1: setup then data write; the addressed partition reads status
// R2: codes 40h/10h word, E8h/D0h buffered
// R3: data cycle address chooses stored location
// R4: only one partition programs at once
// R5: programming only clears ones to zeros
// R6: programming partition reads status until new command
// R7: read status elsewhere sets that partition's status
// R8: status bit 7 shows busy or finished
// R9: busy partition takes only read-type commands
// R10: failure bit 4, supply bit 3, lock bit 1
// R11: host checks then clears status afterwards
// R12: 32-word buffer programmed as one unit
// R13: after buffer setup bit 7 means buffer free
// R14: count write follows setup, at most capacity
// R15: data addresses stay within start plus count
// R16: unaligned load crossing 32 words doubles time
// R17: confirm to original block starts the transfer
// R18: non-confirm gives sequence error bits 7,5,4
// R19: array fault stops, sets bits 7 and 4
// R20: other partitions readable while buffer programs
// R21: crossing erase block aborts, bits 5 and 4
// R22: low supply at buffered setup sets bits 4,3
// R23: after completion a fresh buffered setup allowed
// R24: other writes ignored while busy, bit 7 clear
`timescale 1ns/1ns
module fwb_dev_end
   import fwb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   fwb_bus_if.dev bus,
   input wire logic vpp_ok,
   input wire logic block_lock,
   input wire logic prog_fault,
   output logic engine_busy
);
   import fwb_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WP_DATA = 3'b001,
      ST_WP_BUSY = 3'b010,
      ST_BP_COUNT = 3'b011,
      ST_BP_LOAD = 3'b100,
      ST_BP_CONFIRM = 3'b101,
      ST_BP_BUSY = 3'b110
   } fwb_state_e;

   fwb_state_e state_q;
   logic [DATA_W-1:0] mem_q [MEM_WORDS];
   logic [DATA_W-1:0] buf_q [BUF_WORDS];
   logic [BUF_WORDS-1:0] buf_vld_q;
   fwb_rdmode_e mode_q [2];
   logic [7:0] sr_q;
   logic [TMR_W-1:0] tmr_q;
   logic [ADDR_W-1:0] wp_addr_q;
   logic [DATA_W-1:0] wp_data_q;
   logic [ADDR_W-1:0] blk_addr_q;
   logic [ADDR_W-1:0] start_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] loaded_q;
   logic range_err_q;
   logic vpp_meta_q, vpp_q;
   logic lock_meta_q, lock_q;
   logic fault_meta_q, fault_q;
   logic [DATA_W-1:0] rdata_q;
   logic rvalid_q;
   logic busy_out_q;

   logic [7:0] cmd;
   logic wpart;
   logic busy;
   logic finish;
   logic [7:0] eng_err;
   logic [7:0] status_word;
   logic [ADDR_W:0] bp_end;
   logic cross_blk;
   logic cross_row;
   logic confirm_ok;
   logic count_ok;
   logic [ADDR_W-1:0] off;
   logic [7:0] sr_set;
   logic sr_clr;

   assign cmd = bus.wdata[7:0];
   assign wpart = fwb_part_of(bus.addr);
   assign busy = (state_q == ST_WP_BUSY) || (state_q == ST_BP_BUSY);
   assign finish = busy && (tmr_q == '0);
   assign status_word = sr_q | (busy ? 8'h00 : SR_READY_M); // R8 R13 R24
   assign bp_end = {1'b0, start_q} + (ADDR_W+1)'(count_q) - 9'h001;
   assign cross_blk = bp_end[ADDR_W] ||
      (fwb_blk_of(bp_end[ADDR_W-1:0]) != fwb_blk_of(start_q)); // R21
   assign cross_row = ({1'b0, start_q[IDX_W-1:0]} + count_q) >
      CNT_W'(BUF_WORDS); // R16
   assign confirm_ok = (cmd == CMD_BUF_CONFIRM) && !range_err_q &&
      (fwb_blk_of(bus.addr) == fwb_blk_of(blk_addr_q)); // R17
   assign count_ok = (bus.wdata != '0) &&
      (bus.wdata <= DATA_W'(BUF_WORDS)); // R14
   assign off = (loaded_q == '0) ? '0 : bus.addr - start_q;

   // engine outcome, supply first, then lock, then array fault
   always_comb begin
      if (!vpp_q) begin
         eng_err = SR_SUPPLY_M | SR_PROG_M; // R10
      end else if (lock_q) begin
         eng_err = SR_LOCK_M | SR_PROG_M; // R10
      end else if (fault_q) begin
         eng_err = SR_PROG_M; // R10 R19
      end else begin
         eng_err = 8'h00;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         vpp_meta_q <= 1'b0;
         vpp_q <= 1'b0;
         lock_meta_q <= 1'b0;
         lock_q <= 1'b0;
         fault_meta_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         vpp_meta_q <= vpp_ok;
         vpp_q <= vpp_meta_q;
         lock_meta_q <= block_lock;
         lock_q <= lock_meta_q;
         fault_meta_q <= prog_fault;
         fault_q <= fault_meta_q;
      end
   end

   always_comb begin
      sr_set = 8'h00;
      sr_clr = 1'b0;
      if (finish) begin
         sr_set = eng_err;
      end
      if (bus.we) begin
         case (state_q)
            ST_IDLE: begin
               if (cmd == CMD_CLEAR_STATUS) begin
                  sr_clr = 1'b1;
               end else if (cmd == CMD_BUF_SETUP && !vpp_q) begin
                  sr_set = SR_PROG_M | SR_SUPPLY_M; // R22
               end
            end
            ST_BP_COUNT: begin
               if (!count_ok) begin
                  sr_set = SR_SEQ_M | SR_PROG_M; // R14
               end
            end
            ST_BP_CONFIRM: begin
               if (!confirm_ok || cross_blk) begin
                  sr_set = SR_SEQ_M | SR_PROG_M; // R18 R21
               end
            end
            default: begin
            end
         endcase
      end
   end

   // a set in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sr_q <= 8'h00;
      end else begin
         sr_q <= (sr_clr ? 8'h00 : sr_q) | sr_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         tmr_q <= '0;
         wp_addr_q <= '0;
         wp_data_q <= '0;
         blk_addr_q <= '0;
         start_q <= '0;
         count_q <= '0;
         loaded_q <= '0;
         range_err_q <= 1'b0;
         buf_vld_q <= '0;
         for (int i = 0; i < BUF_WORDS; i++) begin
            buf_q[i] <= ERASED_WORD;
         end
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (bus.we) begin
                  if (cmd == CMD_WORD_PROG || cmd == CMD_WORD_PROG_ALT) begin
                     state_q <= ST_WP_DATA; // R2
                  end else if (cmd == CMD_BUF_SETUP && vpp_q) begin
                     state_q <= ST_BP_COUNT; // R2 R13 R23
                     blk_addr_q <= bus.addr;
                  end
               end
            end
            ST_WP_DATA: begin
               if (bus.we) begin
                  wp_addr_q <= bus.addr; // R3
                  wp_data_q <= bus.wdata;
                  tmr_q <= TMR_W'(WORD_PROG_CYC - 1);
                  state_q <= ST_WP_BUSY;
               end
            end
            ST_BP_COUNT: begin
               if (bus.we) begin
                  if (count_ok) begin
                     count_q <= bus.wdata[CNT_W-1:0];
                     loaded_q <= '0;
                     range_err_q <= 1'b0;
                     buf_vld_q <= '0;
                     state_q <= ST_BP_LOAD;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_BP_LOAD: begin
               if (bus.we) begin
                  if (loaded_q == '0) begin
                     start_q <= bus.addr;
                  end
                  if (off >= ADDR_W'(count_q)) begin
                     range_err_q <= 1'b1; // R15
                  end else begin
                     buf_q[off[IDX_W-1:0]] <= bus.wdata; // R12
                     buf_vld_q[off[IDX_W-1:0]] <= 1'b1;
                  end
                  loaded_q <= loaded_q + 6'h01;
                  if (loaded_q + 6'h01 == count_q) begin
                     state_q <= ST_BP_CONFIRM;
                  end
               end
            end
            ST_BP_CONFIRM: begin
               if (bus.we) begin
                  if (confirm_ok && !cross_blk) begin
                     tmr_q <= cross_row ? TMR_W'(2 * BUF_PROG_CYC - 1) :
                        TMR_W'(BUF_PROG_CYC - 1); // R16
                     state_q <= ST_BP_BUSY; // R17
                  end else begin
                     state_q <= ST_IDLE; // R18 R21
                  end
               end
            end
            ST_WP_BUSY, ST_BP_BUSY: begin
               if (finish) begin
                  state_q <= ST_IDLE; // R19 R23
               end else begin
                  tmr_q <= tmr_q - 10'h001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // array commits at the end of the timed run, only on success
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem_q[i] <= ERASED_WORD;
         end
      end else if (finish && eng_err == 8'h00) begin
         if (state_q == ST_WP_BUSY) begin
            mem_q[wp_addr_q] <= mem_q[wp_addr_q] & wp_data_q; // R3 R5
         end else begin
            for (int i = 0; i < BUF_WORDS; i++) begin
               if (buf_vld_q[i]) begin
                  mem_q[start_q + ADDR_W'(i)] <=
                     mem_q[start_q + ADDR_W'(i)] & buf_q[i]; // R5 R12
               end
            end
         end
      end
   end

   // read mode per partition; buffer phases take writes as data
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mode_q[0] <= FWB_RD_ARRAY;
         mode_q[1] <= FWB_RD_ARRAY;
      end else if (bus.we) begin
         if (state_q == ST_IDLE || busy) begin
            case (cmd)
               CMD_READ_STATUS: mode_q[wpart] <= FWB_RD_STATUS; // R7 R9
               CMD_READ_ARRAY: mode_q[wpart] <= FWB_RD_ARRAY; // R9
               CMD_READ_ID: mode_q[wpart] <= FWB_RD_ID; // R9
               CMD_QUERY: mode_q[wpart] <= FWB_RD_QUERY; // R9
               CMD_WORD_PROG, CMD_WORD_PROG_ALT, CMD_BUF_SETUP: begin
                  if (!busy) begin
                     mode_q[wpart] <= FWB_RD_STATUS; // R1 R4 R24
                  end
               end
               default: begin
               end
            endcase
         end else if (state_q == ST_WP_DATA) begin
            mode_q[wpart] <= FWB_RD_STATUS; // R1 R6
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         busy_out_q <= 1'b0;
      end else begin
         rvalid_q <= bus.re;
         busy_out_q <= busy;
         if (bus.re) begin
            case (mode_q[fwb_part_of(bus.addr)])
               FWB_RD_ARRAY: rdata_q <= mem_q[bus.addr]; // R20
               FWB_RD_STATUS: rdata_q <= {8'h00, status_word}; // R6
               FWB_RD_ID: rdata_q <= ID_WORD;
               default: rdata_q <= QUERY_WORD;
            endcase
         end
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.rvalid = rvalid_q;
   assign engine_busy = busy_out_q;
endmodule // fwb_dev_end

// ---- hdl/fwb_host_end.sv ----
`timescale 1ns/1ns
module fwb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = PTR_W + 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q, rd_q;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic ready_q;
   logic push, pop;

   assign push = in_valid && ready_q;
   assign pop = out_valid && out_ready;
   assign cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];
   assign in_ready = ready_q;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ready_q <= cnt_d != CNT_W'(DEPTH);
         if (push) begin
            wr_q <= bump(wr_q);
         end
         if (pop) begin
            rd_q <= bump(rd_q);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule // fwb_fifo

module fwb_host_end
   import fwb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   fwb_bus_if.host bus,
   input wire logic req_valid,
   output logic req_ready,
   input wire fwb_pkg::fwb_op_e req_op,
   input wire logic [fwb_pkg::ADDR_W-1:0] req_addr,
   input wire logic [fwb_pkg::DATA_W-1:0] req_data,
   output logic rsp_valid,
   output logic [fwb_pkg::DATA_W-1:0] rsp_data
);
   import fwb_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_READ_WAIT = 3'b001,
      H_WP_DATA = 3'b010,
      H_POLL = 3'b011,
      H_POLL_WAIT = 3'b100,
      H_CLEAR = 3'b101
   } fwb_hstate_e;

   fwb_hstate_e state_q;
   logic q_valid;
   logic [REQ_W-1:0] q_data;
   logic [ADDR_W-1:0] op_addr_q;
   logic [DATA_W-1:0] op_data_q;
   logic we_q, re_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic rsp_valid_q;
   logic [DATA_W-1:0] rsp_data_q;
   fwb_op_e q_op;
   logic [ADDR_W-1:0] q_addr;
   logic [DATA_W-1:0] q_wdata;

   fwb_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data({req_op, req_addr, req_data}),
      .out_valid(q_valid),
      .out_ready(state_q == H_IDLE),
      .out_data(q_data)
   );

   assign q_op = fwb_op_e'(q_data[REQ_W-1 -: 2]);
   assign q_addr = q_data[DATA_W +: ADDR_W];
   assign q_wdata = q_data[DATA_W-1:0];

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= H_IDLE;
         op_addr_q <= '0;
         op_data_q <= '0;
         we_q <= 1'b0;
         re_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= '0;
      end else begin
         we_q <= 1'b0;
         re_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         case (state_q)
            H_IDLE: begin
               if (q_valid) begin
                  addr_q <= q_addr;
                  op_addr_q <= q_addr;
                  op_data_q <= q_wdata;
                  case (q_op)
                     FWB_OP_WRITE: begin
                        we_q <= 1'b1;
                        wdata_q <= q_wdata;
                     end
                     FWB_OP_READ: begin
                        re_q <= 1'b1;
                        state_q <= H_READ_WAIT;
                     end
                     default: begin
                        we_q <= 1'b1;
                        wdata_q <= {8'h00, CMD_WORD_PROG}; // R1 R2
                        state_q <= H_WP_DATA;
                     end
                  endcase
               end
            end
            H_READ_WAIT: begin
               if (bus.rvalid) begin
                  rsp_valid_q <= 1'b1;
                  rsp_data_q <= bus.rdata;
                  state_q <= H_IDLE;
               end
            end
            H_WP_DATA: begin
               we_q <= 1'b1;
               wdata_q <= op_data_q; // R1 R3
               state_q <= H_POLL;
            end
            H_POLL: begin
               re_q <= 1'b1;
               addr_q <= op_addr_q;
               state_q <= H_POLL_WAIT;
            end
            H_POLL_WAIT: begin
               if (bus.rvalid) begin
                  if (bus.rdata[SR_READY_BIT]) begin
                     rsp_valid_q <= 1'b1; // R8 R11
                     rsp_data_q <= bus.rdata;
                     state_q <= H_CLEAR;
                  end else begin
                     state_q <= H_POLL;
                  end
               end
            end
            H_CLEAR: begin
               we_q <= 1'b1;
               wdata_q <= {8'h00, CMD_CLEAR_STATUS}; // R11
               state_q <= H_IDLE;
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   assign bus.we = we_q;
   assign bus.re = re_q;
   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_data = rsp_data_q;
endmodule // fwb_host_end

// ---- tb/fwb_bus_checker.sv ----
`timescale 1ns/1ns
module fwb_bus_checker (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic we,
   input wire logic re,
   input wire logic [fwb_pkg::ADDR_W-1:0] addr,
   input wire logic [fwb_pkg::DATA_W-1:0] wdata,
   input wire logic [fwb_pkg::DATA_W-1:0] rdata,
   input wire logic rvalid
);
   import fwb_pkg::*;
   logic setup_q, part_q, stat_q, same_q;
   logic [7:0] cnt_q, rcnt_q;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         setup_q <= 1'b0;
      end else if (we) begin
         setup_q <= wdata == 16'h0040 || wdata == 16'h0010;
      end
   end
   // cycles since the word program data write
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cnt_q <= 8'h00;
      end else if (we && setup_q) begin
         cnt_q <= 8'h01;
      end else if (we && cnt_q >= 8'h64) begin
         cnt_q <= 8'h00;
      end else if (cnt_q != 8'h00 && cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         part_q <= 1'b0;
         stat_q <= 1'b0;
      end else if (we && setup_q) begin
         part_q <= addr[PART_BIT];
         stat_q <= 1'b1;
      end else if (we && addr[PART_BIT] == part_q) begin
         if (wdata[7:0] == 8'h70) begin
            stat_q <= 1'b1;
         end else if (wdata[7:0] inside {8'h90, 8'h98, 8'hff}) begin
            stat_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         same_q <= 1'b0;
         rcnt_q <= 8'h00;
      end else begin
         same_q <= re && addr[PART_BIT] == part_q && stat_q;
         rcnt_q <= cnt_q;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_read_answer: assert property (re |=> rvalid)
      else $error("read without answer");
   a_answer_cause: assert property (rvalid |-> $past(re))
      else $error("answer without read");
   a_strobe_excl: assert property (!(we && re))
      else $error("read and write together");
   a_rdata_holds: assert property (!re |=> $stable(rdata))
      else $error("read data moved");
   a_busy_status: assert property (rvalid && same_q &&
      rcnt_q inside {[8'h01:8'h5f]} |-> !rdata[7])
      else $error("ready while programming");
   a_ready_status: assert property (rvalid && same_q &&
      rcnt_q >= 8'h69 |-> rdata[7])
      else $error("busy after program time");
   a_status_low: assert property (rvalid && same_q &&
      rcnt_q != 8'h00 |-> rdata[15:8] == 8'h00)
      else $error("status word high byte set");
   a_clear_after: assert property (rvalid && same_q &&
      rcnt_q >= 8'h69 && rdata[7] |-> ##[1:8] we && wdata == 16'h0050)
      else $error("status not cleared");
endmodule // fwb_bus_checker

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   import fwb_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic vpp_ok = 1'b1;
   logic block_lock = 1'b0;
   logic prog_fault = 1'b0;
   logic req_valid = 1'b0;
   fwb_op_e req_op = FWB_OP_WRITE;
   logic [ADDR_W-1:0] req_addr = 8'h00;
   logic [DATA_W-1:0] req_data = 16'h0000;
   logic req_ready, rsp_valid, engine_busy;
   logic [DATA_W-1:0] rsp_data;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] msk_q[$];
   logic [31:0] rnd = 32'h00007978;
   int miscompares = 0;
   int comparisons = 0;
   always #10 sys_clk = ~sys_clk;
   fwb_bus_if bus_if ();
   fwb_dev_end fwb_dev_end_inst (.sys_clk(sys_clk), .resetn(resetn),
      .bus(bus_if), .vpp_ok(vpp_ok), .block_lock(block_lock),
      .prog_fault(prog_fault), .engine_busy(engine_busy));
   fwb_host_end fwb_host_end_inst (.sys_clk(sys_clk), .resetn(resetn),
      .bus(bus_if), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   fwb_bus_checker fwb_bus_checker_inst (.sys_clk(sys_clk),
      .resetn(resetn), .we(bus_if.we), .re(bus_if.re),
      .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .rvalid(bus_if.rvalid));
   function automatic logic [15:0] rn();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd[15:0] | 16'h0001;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] e);
      comparisons++;
      if (got !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   always @(posedge sys_clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(rsp_data, ~rsp_data);
         else chk(rsp_data & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   task automatic send(input fwb_op_e op, input logic [7:0] a,
      input logic [15:0] d);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      @(negedge sys_clk);
      while (req_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
      input logic [15:0] m = 16'hffff);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      send(FWB_OP_READ, a, 16'h0000);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      send(FWB_OP_WRITE, a, d);
   endtask
   task automatic wp(input logic [7:0] a, input logic [15:0] d,
      input logic [15:0] e);
      exp_q.push_back(e);
      msk_q.push_back(16'hffff);
      send(FWB_OP_WORD_PROG, a, d);
   endtask
   task automatic settle(input int n);
      req_valid <= 1'b0;
      repeat (n + 1) @(posedge sys_clk);
      for (int k = 0; k < 3000 && exp_q.size() != 0; k++) begin
         @(posedge sys_clk);
      end
   endtask
   task stop_test;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      miscompares++;
      $display("watchdog expired");
      stop_test();
   end
   initial begin
      int i;
      int k;
      logic [15:0] d;
      logic [15:0] n;
      logic [7:0] a;
      for (i = 0; i < MEM_WORDS; i++) mem[i] = 16'hffff;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      for (i = 0; i < 2; i++) begin
         d = rn();
         mem[5] &= d;
         wp(8'h05, d, 16'h0080);
      end
      wr(8'h05, 16'h00ff);
      rd(8'h05, mem[5]);
      settle(5);
      $display("word program test done");
      for (i = 0; i < 3; i++) begin
         vpp_ok <= i != 0;
         block_lock <= i == 1;
         prog_fault <= i == 2;
         settle(4);
         wp(8'h06, rn(),
            i == 0 ? 16'h0098 : i == 1 ? 16'h0092 : 16'h0090);
         wr(8'h06, 16'h00ff);
         rd(8'h06, 16'hffff);
         settle(5);
      end
      prog_fault <= 1'b0;
      $display("program failure test done");
      d = rn();
      mem[5] &= d;
      wr(8'h05, 16'h0010);
      wr(8'h05, d);
      rd(8'h85, mem[8'h85]);
      wr(8'h85, 16'h0070);
      rd(8'h85, 16'h0000, 16'h0080);
      wr(8'h05, 16'h00e8);
      wr(8'h05, 16'h0090);
      rd(8'h05, ID_WORD);
      wr(8'h05, 16'h0098);
      rd(8'h05, QUERY_WORD);
      wr(8'h05, 16'h0070);
      settle(0);
      chk({15'h0000, engine_busy}, 16'h0001);
      settle(130);
      chk({15'h0000, engine_busy}, 16'h0000);
      rd(8'h05, 16'h0080);
      wr(8'h05, 16'h0050);
      wr(8'h05, 16'h00ff);
      rd(8'h05, mem[5]);
      settle(5);
      $display("busy partition test done");
      for (i = 0; i < 3; i++) begin
         a = i == 2 ? 8'h50 : 8'h40;
         n = i == 0 ? 16'h0005 : 16'h0020;
         wr(8'h40, 16'h00e8);
         rd(8'h40, 16'h0080, 16'h0080);
         wr(8'h40, n);
         for (k = 0; k < n; k++) begin
            d = rn();
            mem[a + k] &= d;
            wr(a + k[7:0], d);
         end
         wr(8'h40, 16'h00d0);
         rd(8'h40, 16'h0000, 16'h0080);
         settle(500);
         rd(8'h40, i == 2 ? 16'h0000 : 16'h0080, 16'h0080);
         settle(400);
         rd(8'h40, 16'h0080);
         wr(8'h40, 16'h0050);
         wr(8'h40, 16'h00ff);
         for (k = 0; k < n; k++) rd(a + k[7:0], mem[a + k]);
         settle(5);
      end
      $display("buffered program test done");
      wr(8'h85, 16'h00ff);
      settle(5);
      d = rn();
      mem[7] &= d;
      wp(8'h07, d, 16'h0080);
      for (k = 0; k < 4; k++) rd(8'h88 + k[7:0], mem[8'h88 + k]);
      req_valid <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({15'h0000, req_ready}, 16'h0000);
      @(posedge sys_clk);
      rd(8'h8c, mem[8'h8c]);
      settle(5);
      $display("queue full test done");
      for (i = 0; i < 4; i++) begin
         vpp_ok <= i != 3;
         settle(4);
         wr(8'h40, 16'h00e8);
         if (i < 3) wr(8'h40, i == 2 ? 16'h0021 : 16'h0002);
         if (i < 2) begin
            wr(i != 0 ? 8'h7f : 8'h40, rn());
            wr(i != 0 ? 8'h80 : 8'h41, rn());
            wr(8'h40, i != 0 ? 16'h00d0 : 16'h0077);
         end
         rd(8'h40, i == 3 ? 16'h0098 : 16'h00b0);
         wr(8'h40, 16'h0050);
         settle(5);
      end
      $display("sequence error test done");
      stop_test();
   end
endmodule // testbench
